/* File: inc/txpie_pkg.sv */
// ===========================================================
// transmit path interrupt enable: shared constants
package txpie_pkg;

	// register byte addresses on the slave bus
	localparam int unsigned  TXPIE_ADDR_W      = 12;
	localparam logic [11:0]  TXPIE_OFF_STATUS  = 12'h248;
	localparam logic [11:0]  TXPIE_OFF_ENABLE  = 12'h24C;
	localparam logic [11:0]  TXPIE_OFF_FLUSH   = 12'h300;

	// route masks over the twenty status/enable bits
	localparam logic [19:0]  TXPIE_ROUTE_ONE   = 20'hF0000;
	localparam logic [19:0]  TXPIE_ROUTE_ZERO  = 20'h0FFFF;

	// lowest bit of each four-bit field
	localparam int unsigned  TXPIE_POS_DBC_LO  = 16;
	localparam int unsigned  TXPIE_POS_HDR_LO  = 12;
	localparam int unsigned  TXPIE_POS_FLS_HI  = 8;
	localparam int unsigned  TXPIE_POS_DBC_HI  = 4;
	localparam int unsigned  TXPIE_POS_HDR_HI  = 0;

	// values after reset
	localparam logic [19:0]  TXPIE_RST_STATUS  = 20'h00000;
	localparam logic [19:0]  TXPIE_RST_ENABLE  = 20'h00000;
	localparam logic [3:0]   TXPIE_RST_FLUSH   = 4'h0;

	// bus answers
	localparam logic [1:0]   TXPIE_RESP_OKAY   = 2'h0;
	localparam logic [31:0]  TXPIE_RD_ZERO     = 32'h00000000;

endpackage

/* File: inc/txpie_reg_if.sv */
// ===========================================================
// register strobes between bus slave and register file
interface txpie_reg_if;
	logic        wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        rd_en;
	logic [11:0] rd_addr;
	logic [31:0] rd_data;

	modport bus
	(
		output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input  rd_data
	);

	modport regs
	(
		input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output rd_data
	);
endinterface

/* File: design/txpie_axil_slave.sv */
// ===========================================================
// axi4-lite slave front end, one write and one read in flight
module txpie_axil_slave
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output wire logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output wire logic        wready,
	output wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output wire logic        arready,
	output wire logic [31:0] rdata,
	output wire logic        rvalid,
	input  wire logic        rready,
	txpie_reg_if.bus         rif
);
	logic        awready_r;
	logic        wready_r;
	logic        aw_held_r;
	logic        w_held_r;
	logic        bvalid_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic [31:0] rdata_r;

	wire aw_hs  = awvalid && awready_r;
	wire w_hs   = wvalid && wready_r;
	wire b_hs   = bvalid_r && bready;
	wire ar_hs  = arvalid && arready_r;
	wire r_hs   = rvalid_r && rready;
	// commit waits for the previous response to drain
	wire commit = aw_held_r && w_held_r && !bvalid_r;

	// ===========================================================
	// write channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
			awaddr_r  <= 12'h000;
		end
		else if (aw_hs)
		begin
			awready_r <= 1'b0;
			aw_held_r <= 1'b1;
			awaddr_r  <= awaddr;
		end
		else if (commit)
		begin
			awready_r <= 1'b1;
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
		end
		else if (w_hs)
		begin
			wready_r <= 1'b0;
			w_held_r <= 1'b1;
			wdata_r  <= wdata;
			wstrb_r  <= wstrb;
		end
		else if (commit)
		begin
			wready_r <= 1'b1;
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bvalid_r <= 1'b0;
		else if (commit)
			bvalid_r <= 1'b1;
		else if (b_hs)
			bvalid_r <= 1'b0;
	end

	// ===========================================================
	// read channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
		end
		else if (ar_hs)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rdata_r   <= rif.rd_data;
		end
		else if (r_hs)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
		end
	end

	assign rif.wr_en   = commit;
	assign rif.wr_addr = awaddr_r;
	assign rif.wr_data = wdata_r;
	assign rif.wr_strb = wstrb_r;
	assign rif.rd_en   = ar_hs;
	assign rif.rd_addr = araddr;
	assign awready     = awready_r;
	assign wready      = wready_r;
	assign bvalid      = bvalid_r;
	assign arready     = arready_r;
	assign rvalid      = rvalid_r;
	assign rdata       = rdata_r;
endmodule

/* File: design/txpie_top.sv */
// What this block does
// - enables 19:16 route continuity errors of buffers 0-3 to summary one.
// - enables 15:12 route header errors of buffers 0-3 to summary zero.
// - enables 11:8 route flush events of buffers 4-7 to summary zero.
// - enables 7:4 route continuity errors of buffers 4-7 to summary zero.
// - enables 3:0 route header errors of buffers 4-7 to summary zero.
// - a cleared enable hides its status bit; status still sets.
// - all twenty enables are read/write and reset to zero.
// - detected transmit path errors set the matching status bits.
// - flush status sets only when that buffer's flush-on-error is on.
//
// Chosen here: register access over AXI4-Lite.
module txpie_top
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axil_awaddr,
	input  wire logic        s_axil_awvalid,
	output wire logic        s_axil_awready,
	input  wire logic [31:0] s_axil_wdata,
	input  wire logic [3:0]  s_axil_wstrb,
	input  wire logic        s_axil_wvalid,
	output wire logic        s_axil_wready,
	output wire logic [1:0]  s_axil_bresp,
	output wire logic        s_axil_bvalid,
	input  wire logic        s_axil_bready,
	input  wire logic [11:0] s_axil_araddr,
	input  wire logic        s_axil_arvalid,
	output wire logic        s_axil_arready,
	output wire logic [31:0] s_axil_rdata,
	output wire logic [1:0]  s_axil_rresp,
	output wire logic        s_axil_rvalid,
	input  wire logic        s_axil_rready,
	input  wire logic [7:0]  continuity_err_evt,
	input  wire logic [7:0]  header_err_evt,
	input  wire logic [3:0]  flush_err_evt,
	output wire logic        sys_summary_tx_irq_zero,
	output wire logic        sys_summary_tx_irq_one,
	output wire logic        irq
);
	// ===========================================================
	// state
	logic [19:0] tx_path_irq_status_r;
	logic [19:0] tx_path_irq_status_nxt;
	logic [19:0] tx_path_irq_enable_r;
	logic [19:0] tx_path_irq_enable_nxt;
	logic [3:0]  flush_on_error_enable_r;
	logic [3:0]  flush_on_error_enable_nxt;
	logic        sum_zero_r;
	logic        sum_one_r;
	logic        irq_r;

	txpie_reg_if rif ();

	// ===========================================================
	// bus slave
	txpie_axil_slave u_slave
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axil_awaddr),
		.awvalid (s_axil_awvalid),
		.awready (s_axil_awready),
		.wdata   (s_axil_wdata),
		.wstrb   (s_axil_wstrb),
		.wvalid  (s_axil_wvalid),
		.wready  (s_axil_wready),
		.bvalid  (s_axil_bvalid),
		.bready  (s_axil_bready),
		.araddr  (s_axil_araddr),
		.arvalid (s_axil_arvalid),
		.arready (s_axil_arready),
		.rdata   (s_axil_rdata),
		.rvalid  (s_axil_rvalid),
		.rready  (s_axil_rready),
		.rif     (rif)
	);

	assign s_axil_bresp = txpie_pkg::TXPIE_RESP_OKAY;
	assign s_axil_rresp = txpie_pkg::TXPIE_RESP_OKAY;

	// ===========================================================
	// address decode and byte lanes
	wire wr_status = rif.wr_en
		&& rif.wr_addr == txpie_pkg::TXPIE_OFF_STATUS;
	wire wr_enable = rif.wr_en
		&& rif.wr_addr == txpie_pkg::TXPIE_OFF_ENABLE;
	wire wr_flush  = rif.wr_en
		&& rif.wr_addr == txpie_pkg::TXPIE_OFF_FLUSH;

	wire [31:0] wmask = {{8{rif.wr_strb[3]}}, {8{rif.wr_strb[2]}},
		{8{rif.wr_strb[1]}}, {8{rif.wr_strb[0]}}};
	wire [31:0] wbits = rif.wr_data & wmask;

	// ===========================================================
	// status: events set, write one clears, set wins
	wire [3:0]  flush_qual = flush_err_evt & flush_on_error_enable_r;
	wire [19:0] evt_set = {
		continuity_err_evt[0], continuity_err_evt[1],
		continuity_err_evt[2], continuity_err_evt[3],
		header_err_evt[0], header_err_evt[1],
		header_err_evt[2], header_err_evt[3],
		flush_qual[0], flush_qual[1], flush_qual[2], flush_qual[3],
		continuity_err_evt[4], continuity_err_evt[5],
		continuity_err_evt[6], continuity_err_evt[7],
		header_err_evt[4], header_err_evt[5],
		header_err_evt[6], header_err_evt[7]};
	wire [19:0] status_clr = wr_status ? wbits[19:0] : 20'h00000;

	// status sets regardless of its enable
	assign tx_path_irq_status_nxt =
		(tx_path_irq_status_r & ~status_clr) | evt_set;

	assign tx_path_irq_enable_nxt = wr_enable
		? (tx_path_irq_enable_r & ~wmask[19:0]) | wbits[19:0]
		: tx_path_irq_enable_r;

	assign flush_on_error_enable_nxt = wr_flush
		? (flush_on_error_enable_r & ~wmask[3:0]) | wbits[3:0]
		: flush_on_error_enable_r;

	// ===========================================================
	// routing onto the two summaries
	wire [19:0] gated = tx_path_irq_status_r & tx_path_irq_enable_r;
	wire [19:0] route_one  = gated & txpie_pkg::TXPIE_ROUTE_ONE;
	// header, flush and upper continuity fields share summary zero
	wire [19:0] route_zero = gated & txpie_pkg::TXPIE_ROUTE_ZERO;
	wire        sum_one_nxt  = |route_one;
	wire        sum_zero_nxt = |route_zero;

	// ===========================================================
	// read mux, unmapped addresses read zero
	assign rif.rd_data =
		(rif.rd_addr == txpie_pkg::TXPIE_OFF_STATUS)
			? {12'h000, tx_path_irq_status_r} :
		(rif.rd_addr == txpie_pkg::TXPIE_OFF_ENABLE)
			? {12'h000, tx_path_irq_enable_r} :
		(rif.rd_addr == txpie_pkg::TXPIE_OFF_FLUSH)
			? {28'h0000000, flush_on_error_enable_r} :
		txpie_pkg::TXPIE_RD_ZERO;

	// ===========================================================
	// registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_path_irq_status_r    <= txpie_pkg::TXPIE_RST_STATUS;
			tx_path_irq_enable_r    <= txpie_pkg::TXPIE_RST_ENABLE;
			flush_on_error_enable_r <= txpie_pkg::TXPIE_RST_FLUSH;
		end
		else
		begin
			tx_path_irq_status_r    <= tx_path_irq_status_nxt;
			tx_path_irq_enable_r    <= tx_path_irq_enable_nxt;
			flush_on_error_enable_r <= flush_on_error_enable_nxt;
		end
	end

	// summaries re-evaluated every edge, one cycle behind status
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sum_zero_r <= 1'b0;
			sum_one_r  <= 1'b0;
			irq_r      <= 1'b0;
		end
		else
		begin
			sum_zero_r <= sum_zero_nxt;
			sum_one_r  <= sum_one_nxt;
			irq_r      <= sum_zero_nxt | sum_one_nxt;
		end
	end

	assign sys_summary_tx_irq_zero = sum_zero_r;
	assign sys_summary_tx_irq_one  = sum_one_r;
	assign irq                     = irq_r;

	// ===========================================================
	// assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wire [3:0] g_dbc_lo = gated[txpie_pkg::TXPIE_POS_DBC_LO +: 4];
	wire [3:0] g_hdr_lo = gated[txpie_pkg::TXPIE_POS_HDR_LO +: 4];
	wire [3:0] g_fls_hi = gated[txpie_pkg::TXPIE_POS_FLS_HI +: 4];
	wire [3:0] g_dbc_hi = gated[txpie_pkg::TXPIE_POS_DBC_HI +: 4];
	wire [3:0] g_hdr_hi = gated[txpie_pkg::TXPIE_POS_HDR_HI +: 4];

	a_dbc_lo_one: assert property (
		g_dbc_lo != 4'h0 |=> sys_summary_tx_irq_one)
		else $error("enabled low continuity error missed summary one");

	a_hdr_lo_zero: assert property (
		g_hdr_lo != 4'h0 |=> sys_summary_tx_irq_zero)
		else $error("enabled low header error missed summary zero");

	a_flush_zero: assert property (
		g_fls_hi != 4'h0 |=> sys_summary_tx_irq_zero)
		else $error("enabled flush event missed summary zero");

	a_dbc_hi_zero: assert property (
		g_dbc_hi != 4'h0 |=> sys_summary_tx_irq_zero)
		else $error("enabled high continuity error missed summary zero");

	a_hdr_hi_zero: assert property (
		g_hdr_hi != 4'h0 |=> sys_summary_tx_irq_zero)
		else $error("enabled high header error missed summary zero");

	a_masked_quiet: assert property (
		g_dbc_lo == 4'h0 |=> !sys_summary_tx_irq_one)
		else $error("summary one raised with no enabled source");

	a_status_ungated: assert property (
		continuity_err_evt[0] && !tx_path_irq_enable_nxt[19]
		|=> tx_path_irq_status_r[19] && !gated[19])
		else $error("masked continuity error did not set status");

	a_enable_reset: assert property (
		$rose(aresetn) |-> tx_path_irq_enable_r == 20'h00000
		&& !sys_summary_tx_irq_zero && !sys_summary_tx_irq_one)
		else $error("enables not cleared by reset");

	a_enable_write: assert property (
		wr_enable && rif.wr_strb == 4'hF
		|=> tx_path_irq_enable_r == $past(rif.wr_data[19:0]))
		else $error("full enable write not stored");

	a_hdr_event_sets: assert property (
		header_err_evt[7] |=> tx_path_irq_status_r[0])
		else $error("header error of buffer 7 did not set status");

	a_set_wins: assert property (
		continuity_err_evt[4] && wr_status && rif.wr_data[7]
		&& rif.wr_strb[0] |=> tx_path_irq_status_r[7])
		else $error("clear beat a same-cycle continuity event");

	a_flush_gated: assert property (
		!tx_path_irq_status_r[11] && !flush_on_error_enable_r[0]
		&& !wr_flush |=> !tx_path_irq_status_r[11])
		else $error("flush status set without flush-on-error");

	a_flush_taken: assert property (
		flush_err_evt[3] && flush_on_error_enable_r[3]
		|=> tx_path_irq_status_r[8])
		else $error("enabled flush event did not set status");

	a_summary_or: assert property (
		##1 sys_summary_tx_irq_zero == $past(sum_zero_nxt)
		&& sys_summary_tx_irq_one == $past(sum_one_nxt))
		else $error("summary does not follow enabled status");

	// late enable of an already pending bit raises summary zero
	sequence s_pending_masked;
		tx_path_irq_status_r[15] && !tx_path_irq_enable_r[15];
	endsequence

	sequence s_unmasked;
		tx_path_irq_status_r[15] && tx_path_irq_enable_r[15];
	endsequence

	a_late_enable: assert property (
		s_pending_masked ##1 s_unmasked |=> sys_summary_tx_irq_zero
		##0 irq)
		else $error("late enable failed to raise summary zero");

	a_irq_level: assert property (
		(sys_summary_tx_irq_zero || sys_summary_tx_irq_one) == irq)
		else $error("interrupt output disagrees with summaries");

	a_zero_quiet: assert property (
		g_hdr_lo == 4'h0 && g_fls_hi == 4'h0 && g_dbc_hi == 4'h0
		&& g_hdr_hi == 4'h0 |=> !sys_summary_tx_irq_zero)
		else $error("summary zero raised with no enabled source");

	a_irq_quiet: assert property (
		gated == 20'h00000 |=> !irq)
		else $error("interrupt raised with no enabled status");

	a_dbc_lo_sets: assert property (
		continuity_err_evt[0] |=> tx_path_irq_status_r[19])
		else $error("continuity error of buffer 0 did not set status");

	a_dbc_hi_sets: assert property (
		continuity_err_evt[7] |=> tx_path_irq_status_r[4])
		else $error("continuity error of buffer 7 did not set status");

	a_hdr_lo_sets: assert property (
		header_err_evt[0] |=> tx_path_irq_status_r[15])
		else $error("header error of buffer 0 did not set status");

	a_no_stray_set: assert property (
		continuity_err_evt == 8'h00 && header_err_evt == 8'h00
		&& flush_err_evt == 4'h0
		|=> (tx_path_irq_status_r & ~$past(tx_path_irq_status_r))
		== 20'h00000)
		else $error("status bit set with no event");

	a_status_sticky: assert property (
		!wr_status
		|=> (tx_path_irq_status_r & $past(tx_path_irq_status_r))
		== $past(tx_path_irq_status_r))
		else $error("status bit dropped without a clear");

	a_clear_all: assert property (
		wr_status && rif.wr_strb == 4'hF
		&& rif.wr_data[19:0] == 20'hFFFFF
		&& continuity_err_evt == 8'h00 && header_err_evt == 8'h00
		&& flush_err_evt == 4'h0 |=> tx_path_irq_status_r == 20'h00000)
		else $error("full clear left status bits set");

	a_flush_lo_taken: assert property (
		flush_err_evt[0] && flush_on_error_enable_r[0]
		|=> tx_path_irq_status_r[11])
		else $error("enabled flush of buffer 4 did not set status");

	a_flush_dropped: assert property (
		flush_err_evt[3] && !flush_on_error_enable_r[3]
		&& !tx_path_irq_status_r[8] |=> !tx_path_irq_status_r[8])
		else $error("flush of buffer 7 set status while not enabled");

	a_enable_hold: assert property (
		!wr_enable |=> $stable(tx_path_irq_enable_r))
		else $error("enables changed without a write");

	a_state_reset: assert property (
		$rose(aresetn) |-> tx_path_irq_status_r == 20'h00000
		&& flush_on_error_enable_r == 4'h0 && !irq)
		else $error("status or flush config not cleared by reset");

	// armed event, status next edge, summary the edge after
	sequence s_dbc_armed;
		continuity_err_evt[3] && tx_path_irq_enable_r[16]
		&& tx_path_irq_enable_nxt[16];
	endsequence

	sequence s_one_raised;
		sys_summary_tx_irq_one && irq;
	endsequence

	a_dbc_to_one: assert property (
		s_dbc_armed |=> ##1 s_one_raised)
		else $error("enabled continuity error did not reach summary one");

	sequence s_hdr_armed;
		header_err_evt[0] && tx_path_irq_enable_r[15]
		&& tx_path_irq_enable_nxt[15];
	endsequence

	sequence s_zero_raised;
		sys_summary_tx_irq_zero && irq;
	endsequence

	a_hdr_to_zero: assert property (
		s_hdr_armed |=> ##1 s_zero_raised)
		else $error("enabled header error did not reach summary zero");
endmodule

/* File: test/tx_path_irq_enable_low_bench.sv */
module tx_path_irq_enable_low_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk;
	logic        aresetn;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [7:0]  cont;
	logic [7:0]  hdr;
	logic [3:0]  fls;
	logic        sum0;
	logic        sum1;
	logic        irq;
	int          error_cnt;
	int          cmp_count;
	logic [19:0] st_m;
	logic [19:0] en_m;
	logic [3:0]  fl_m;
	logic [19:0] m;
	logic [31:0] rd;

	txpie_top dut
	(
		.aclk                    (aclk),
		.aresetn                 (aresetn),
		.s_axil_awaddr           (awaddr),
		.s_axil_awvalid          (awvalid),
		.s_axil_awready          (awready),
		.s_axil_wdata            (wdata),
		.s_axil_wstrb            (wstrb),
		.s_axil_wvalid           (wvalid),
		.s_axil_wready           (wready),
		.s_axil_bresp            (bresp),
		.s_axil_bvalid           (bvalid),
		.s_axil_bready           (bready),
		.s_axil_araddr           (araddr),
		.s_axil_arvalid          (arvalid),
		.s_axil_arready          (arready),
		.s_axil_rdata            (rdata),
		.s_axil_rresp            (rresp),
		.s_axil_rvalid           (rvalid),
		.s_axil_rready           (rready),
		.continuity_err_evt      (cont),
		.header_err_evt          (hdr),
		.flush_err_evt           (fls),
		.sys_summary_tx_irq_zero (sum0),
		.sys_summary_tx_irq_one  (sum1),
		.irq                     (irq)
	);

	// =========================================================
	// compare and closing
	task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(string nm, logic e, logic g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic results();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// =========================================================
	// bus master, waits bounded only by the watchdog
	task automatic wr_s(logic [11:0] a, logic [31:0] d, logic [3:0] s);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!(bvalid && bready));
		bready <= 1'b0;
		chk_word("bresp", 32'h0, {30'h0, bresp});
		// idle edge: a following call never re-drives in this step
		@(posedge aclk);
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		wr_s(a, d, 4'hF);
	endtask

	task automatic rd_reg(logic [11:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!(rvalid && rready));
		d = rdata;
		rready <= 1'b0;
		chk_word("rresp", 32'h0, {30'h0, rresp});
		@(posedge aclk);
	endtask

	// =========================================================
	// model: event lines to status bit positions
	function automatic logic [19:0] map_evt(logic [7:0] c, logic [7:0] h,
		logic [3:0] f);
		logic [19:0] r;
		r = 20'h0;
		for (int i = 0; i < 4; i++)
		begin
			r[19 - i] = c[i];
			r[15 - i] = h[i];
			r[11 - i] = f[i] & fl_m[i];
			r[7 - i] = c[4 + i];
			r[3 - i] = h[4 + i];
		end
		return r;
	endfunction

	// one-cycle pulse, then status and summary have both landed
	task automatic fire(logic [7:0] c, logic [7:0] h, logic [3:0] f);
		cont <= c;
		hdr <= h;
		fls <= f;
		@(posedge aclk);
		cont <= 8'h0;
		hdr <= 8'h0;
		fls <= 4'h0;
		st_m = st_m | map_evt(c, h, f);
		repeat (3) @(posedge aclk);
	endtask

	task automatic chk_all();
		chk_bit("summary_one", |(st_m & en_m & 20'hF0000), sum1);
		chk_bit("summary_zero", |(st_m & en_m & 20'h0FFFF), sum0);
		chk_bit("irq", |(st_m & en_m), irq);
		rd_reg(12'h248, rd);
		chk_word("status", {12'h0, st_m}, rd);
	endtask

	task automatic set_en(logic [31:0] v);
		wr(12'h24C, v);
		en_m = v[19:0];
	endtask

	task automatic clear_st();
		wr(12'h248, 32'hFFFFFFFF);
		st_m = 20'h0;
		repeat (2) @(posedge aclk);
	endtask

	// =========================================================
	// clock, watchdog, tests
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial
	begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		results();
	end

	initial
	begin
		logic [7:0] c;
		logic [7:0] h;
		logic [3:0] f;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 12'h0;
		araddr = 12'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		{cont, hdr, fls} = 20'h0;
		error_cnt = 0;
		cmp_count = 0;
		{st_m, en_m, fl_m} = 44'h0;
		void'($urandom(56090));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_reg(12'h24C, rd);
		chk_word("enable_reset", 32'h0, rd);
		rd_reg(12'h248, rd);
		chk_word("status_reset", 32'h0, rd);
		set_en(32'hFFFFFFFF);
		wr(12'h104, 32'h0);
		rd_reg(12'h24C, rd);
		chk_word("enable_rw", 32'h000FFFFF, rd);
		// byte lane 1 only: enables 15:8 cleared, rest kept
		wr_s(12'h24C, 32'h0, 4'h2);
		en_m = 20'hF00FF;
		rd_reg(12'h24C, rd);
		chk_word("enable_strb", 32'h000F00FF, rd);
		rd_reg(12'h100, rd);
		chk_word("unmapped", 32'h0, rd);
		wr(12'h300, 32'h0000000F);
		fl_m = 4'hF;
		// each event line alone: routed once, then hidden
		for (int j = 0; j < 20; j++)
		begin
			c = (j < 8) ? 8'h1 << j : 8'h0;
			h = (j >= 8 && j < 16) ? 8'h1 << (j - 8) : 8'h0;
			f = (j >= 16) ? 4'h1 << (j - 16) : 4'h0;
			m = map_evt(c, h, f);
			set_en({12'h0, m});
			fire(c, h, f);
			chk_all();
			clear_st();
			chk_bit("cleared", 1'b0, irq);
			set_en({12'h0, ~m});
			fire(c, h, f);
			chk_all();
			// pending bit enabled late must now reach its summary
			set_en({12'h0, m});
			chk_all();
			clear_st();
		end
		// event held across a full clear: set wins
		cont <= 8'h10;
		wr(12'h248, 32'hFFFFFFFF);
		cont <= 8'h00;
		st_m = 20'h00080;
		repeat (2) @(posedge aclk);
		chk_all();
		clear_st();
		// random enables, flush settings and event mixes
		for (int k = 0; k < 40; k++)
		begin
			set_en($urandom);
			fl_m = 4'($urandom);
			wr(12'h300, {28'h0, fl_m});
			rd_reg(12'h300, rd);
			chk_word("flush_cfg", {28'h0, fl_m}, rd);
			c = 8'($urandom);
			h = 8'($urandom & $urandom);
			f = 4'($urandom);
			fire(c, h, f);
			chk_all();
			if (k[0])
			begin
				fire(8'($urandom), 8'h0, 4'($urandom));
				chk_all();
			end
			clear_st();
		end
		results();
	end
endmodule
